// ===== nvp_pkg.sv
// Shared constants and carrier types for the NVM protection and ID block
package nvp_pkg;

    // ------------------------------------------------------------
    // Geometry and bus
    // ------------------------------------------------------------
    localparam int         NBLK   = 4;       // User memory blocks
    localparam int         AXI_AW = 24;      // Byte address width
    localparam logic [2:0] BOOT_BLK = 3'h4;  // Block number of the boot block

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [21:0] IDX_CODE = 22'h300008;  // code_protect_word
    localparam logic [21:0] IDX_TBL  = 22'h30000a;  // table_read_protect_word
    localparam logic [21:0] IDX_LOCK = 22'h300010;  // self-write lock word
    localparam logic [21:0] IDX_REV  = 22'h3ffffc;  // silicon_revision_word
    localparam logic [21:0] IDX_PART = 22'h3ffffe;  // part_identifier_word

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CODE_PROG_BIT = 0;
    localparam int CODE_DATA_BIT = 1;
    localparam int TBL_BOOT_BIT  = 9;
    localparam int REV_FAM_LSB   = 12;
    localparam int REV_MAJ_LSB   = 6;
    localparam int REV_MIN_LSB   = 0;

    // Family pattern in the revision word; value is arbitrary
    localparam logic [3:0] FAMILY_CODE = 4'h5;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  block_self_write_lock;   // 0 = block write-protected
        logic        data_nvm_read_guard;     // 0 = data NVM protected
        logic        program_read_guard;      // 0 = program memory protected
        logic        boot_table_read_guard;   // 0 = boot block guarded
        logic [3:0]  block_table_read_guard;  // 0 = block guarded
        logic [15:0] part_number_field;
        logic [5:0]  major_silicon_rev;
        logic [5:0]  minor_silicon_rev;
    } nvp_cfg_t;

    // Erased configuration: every protection off, every block open
    localparam nvp_cfg_t CFG_ERASED = '1;

    typedef struct packed {
        logic       valid;     // Request present this cycle
        logic       is_write;  // 1 = self-write, 0 = table read
        logic [2:0] target;    // Block addressed
        logic [2:0] source;    // Block holding the executing code
    } nvp_req_t;

    typedef struct packed {
        logic done;   // One-cycle answer strobe
        logic allow;  // Access permitted
    } nvp_res_t;

endpackage

// ===== nvp_axil_slave.sv
// AXI4-Lite slave front end for the protection register file
module nvp_axil_slave (
    input  wire logic        aclk,     // Clock
    input  wire logic        aresetn,  // Synchronous reset, active low
    input  wire logic [nvp_pkg::AXI_AW-1:0] awaddr,  // Write address
    input  wire logic        awvalid,  // Write address valid
    output logic             awready,  // Write address ready
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic [3:0]  wstrb,    // Byte enables
    input  wire logic        wvalid,   // Write data valid
    output logic             wready,   // Write data ready
    output logic [1:0]       bresp,    // Write response
    output logic             bvalid,   // Write response valid
    input  wire logic        bready,   // Write response ready
    input  wire logic [nvp_pkg::AXI_AW-1:0] araddr,  // Read address
    input  wire logic        arvalid,  // Read address valid
    output logic             arready,  // Read address ready
    output logic [31:0]      rdata,    // Read data
    output logic [1:0]       rresp,    // Read response
    output logic             rvalid,   // Read data valid
    input  wire logic        rready,   // Read data ready
    output logic             wr_fire,  // Write commits this cycle
    output logic [21:0]      wr_idx,   // Index of the committed write
    output logic [31:0]      wr_data,  // Data of the committed write
    output logic [3:0]       wr_strb,  // Byte enables of the write
    input  wire logic        wr_ok,    // Write index is mapped
    output logic [21:0]      rd_idx,   // Index being read
    input  wire logic [31:0] rd_data,  // Read data for rd_idx
    input  wire logic        rd_ok     // Read index is mapped
);
    import nvp_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic        w_have;
        logic        bvalid;
        logic [1:0]  bresp;
        logic [21:0] widx;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } nvp_slv_t;

    localparam nvp_slv_t SLV_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                     default: '0};

    nvp_slv_t s_reg;
    nvp_slv_t s_next;

    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    // Address and data are caught separately, so either may come first
    always_comb begin
        s_next = s_reg;
        if (s_reg.awready && awvalid) begin
            s_next.aw_have = 1'b1;
            s_next.awready = 1'b0;
            s_next.widx    = awaddr[AXI_AW-1:2];
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_have = 1'b1;
            s_next.wready = 1'b0;
            s_next.wdata  = wdata;
            s_next.wstrb  = wstrb;
        end
        if (wr_fire) begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // Ready returns only after the response is gone: one write in flight
        if (s_reg.bvalid && bready) begin
            s_next.bvalid  = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready  = 1'b1;
        end
        if (s_reg.arready && arvalid) begin
            s_next.arready = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rdata   = rd_ok ? rd_data : 32'h0;
            s_next.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_reg.rvalid && rready) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end
        if (!aresetn) begin
            s_next = SLV_RST;
        end
    end

    always_ff @(posedge aclk) begin
        s_reg <= s_next;
    end

    // Outputs straight from the state, except rd_idx, which is taken from araddr
    assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    assign wr_idx  = s_reg.widx;
    assign wr_data = s_reg.wdata;
    assign wr_strb = s_reg.wstrb;
    assign rd_idx  = araddr[AXI_AW-1:2];
    assign awready = s_reg.awready;
    assign wready  = s_reg.wready;
    assign bvalid  = s_reg.bvalid;
    assign bresp   = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid  = s_reg.rvalid;
    assign rresp   = s_reg.rresp;
    assign rdata   = s_reg.rdata;

endmodule

// ===== nvp_access_check.sv
// Per-block self-write and table-read permission check
module nvp_access_check #(
    parameter int NB = 4                      // User memory blocks
) (
    input  wire logic            aclk,        // Clock
    input  wire logic            aresetn,     // Synchronous reset, active low
    input  wire logic [NB-1:0]   wr_lock,     // Self-write lock, 0 = protected
    input  wire logic [NB-1:0]   rd_guard,    // Table-read guard, 0 = protected
    input  wire logic            boot_guard,  // Boot table-read guard, 0 = protected
    input  wire nvp_pkg::nvp_req_t req,       // Access request
    output nvp_pkg::nvp_res_t    res          // Registered answer
);
    import nvp_pkg::*;

    typedef struct packed {
        nvp_res_t res;
    } nvp_chk_t;

    nvp_chk_t      c_reg;
    nvp_chk_t      c_next;
    logic [NB-1:0] rej_wr;
    logic [NB-1:0] rej_rd;
    logic          rej_boot;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Per-block rejection terms
    // ------------------------------------------------------------
    for (genvar i = 0; i < NB; i++) begin : g_blk
        // Code running inside a block may always read that block
        assign rej_wr[i] = req.is_write && req.target == 3'(i) && !wr_lock[i];
        assign rej_rd[i] = !req.is_write && req.target == 3'(i)
                           && req.source != 3'(i) && !rd_guard[i];

        self_write_a: assert property (
            req.valid && req.is_write && req.target == 3'(i)
            |=> res.done && res.allow == $past(wr_lock[i]))
            else $error("self-write answer does not follow the lock bit");

        table_read_a: assert property (
            req.valid && !req.is_write && req.target == 3'(i)
            && req.source != 3'(i) && !rd_guard[i]
            |=> res.done && !res.allow)
            else $error("guarded block table read was allowed");
    end

    assign rej_boot = !req.is_write && req.target == BOOT_BLK
                      && req.source != BOOT_BLK && !boot_guard;

    // ------------------------------------------------------------
    // Answer register
    // ------------------------------------------------------------
    always_comb begin
        c_next           = c_reg;
        c_next.res.done  = req.valid;
        c_next.res.allow = req.valid && !(|rej_wr) && !(|rej_rd) && !rej_boot;
        if (!aresetn) begin
            c_next = '0;
        end
    end

    always_ff @(posedge aclk) begin
        c_reg <= c_next;
    end

    assign res = c_reg.res;

    boot_read_a: assert property (
        req.valid && !req.is_write && req.target == BOOT_BLK
        && req.source != BOOT_BLK && !boot_guard
        |=> res.done && !res.allow)
        else $error("guarded boot block table read was allowed");

endmodule

// ===== nvp_protect_top.sv
// NVM protection and identification words with AXI4-Lite access
//
// What this block does
// - A self-write lock bit at zero blocks self-writes to its user block; at one the block is writable.
// - The data NVM code protection is on when the data guard bit (bit 1) is zero and off when it is one.
// - The program memory code protection is on when the program guard bit (bit 0) is zero and off when one.
// - Both code-protection bits load from configuration memory at reset (one, protection off, if it is not readable) and software can only read them.
// - A zero boot guard bit (bit 9) makes table reads of the boot block from other blocks be rejected.
// - A zero in block guard bits 0 to 3 rejects table reads of that user block from other blocks.
// - The part identifier word is a 16-bit read-only value naming the part and its power variant.
// - Revision word bits 15 to 12 always read a fixed family pattern.
// - Revision word bits 11 to 6 give the six-bit major silicon revision.
// - Revision word bits 5 to 0 give the six-bit minor silicon revision.
//
// Register access over AXI4-Lite was decided locally.
module nvp_protect_top (
    input  wire logic        aclk,              // Clock, 125 MHz
    input  wire logic        aresetn,           // Synchronous reset, active low
    input  wire logic [nvp_pkg::AXI_AW-1:0] awaddr,  // Write address
    input  wire logic        awvalid,           // Write address valid
    output logic             awready,           // Write address ready
    input  wire logic [31:0] wdata,             // Write data
    input  wire logic [3:0]  wstrb,             // Byte enables
    input  wire logic        wvalid,            // Write data valid
    output logic             wready,            // Write data ready
    output logic [1:0]       bresp,             // Write response
    output logic             bvalid,            // Write response valid
    input  wire logic        bready,            // Write response ready
    input  wire logic [nvp_pkg::AXI_AW-1:0] araddr,  // Read address
    input  wire logic        arvalid,           // Read address valid
    output logic             arready,           // Read address ready
    output logic [31:0]      rdata,             // Read data
    output logic [1:0]       rresp,             // Read response
    output logic             rvalid,            // Read data valid
    input  wire logic        rready,            // Read data ready
    input  wire nvp_pkg::nvp_cfg_t cfg_load,    // Configuration memory contents
    input  wire logic        cfg_valid,         // Configuration memory readable
    input  wire nvp_pkg::nvp_req_t mem_req,     // Self-write or table-read request
    output nvp_pkg::nvp_res_t mem_res,          // Permission answer
    output logic             prog_protect_on,   // Program memory code protection
    output logic             data_protect_on    // Data NVM code protection
);
    import nvp_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        nvp_cfg_t cfg;
        logic     prog_on;
        logic     data_on;
    } nvp_top_t;

    nvp_top_t    t_reg;
    nvp_top_t    t_next;
    logic        wr_fire;
    logic [21:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [21:0] rd_idx;
    logic [31:0] rd_data;
    logic        rd_ok;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    nvp_axil_slave u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_fire (wr_fire),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_ok   (wr_ok),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .rd_ok   (rd_ok)
    );

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Unmapped indices answer SLVERR; writes to read-only words are ignored
    always_comb begin
        wr_ok = (wr_idx == IDX_CODE) || (wr_idx == IDX_TBL) || (wr_idx == IDX_LOCK)
                || (wr_idx == IDX_REV) || (wr_idx == IDX_PART);
    end

    // Read multiplexer, reserved bits read as zero
    always_comb begin
        rd_data = 32'h0;
        rd_ok   = 1'b1;
        case (rd_idx)
            IDX_CODE: begin
                rd_data[CODE_DATA_BIT] = t_reg.cfg.data_nvm_read_guard;
                rd_data[CODE_PROG_BIT] = t_reg.cfg.program_read_guard;
            end
            IDX_TBL: begin
                rd_data[TBL_BOOT_BIT]  = t_reg.cfg.boot_table_read_guard;
                rd_data[NBLK-1:0]      = t_reg.cfg.block_table_read_guard;
            end
            IDX_LOCK: begin
                rd_data[NBLK-1:0]      = t_reg.cfg.block_self_write_lock;
            end
            IDX_REV: begin
                rd_data[REV_FAM_LSB+:4] = FAMILY_CODE;
                rd_data[REV_MAJ_LSB+:6] = t_reg.cfg.major_silicon_rev;
                rd_data[REV_MIN_LSB+:6] = t_reg.cfg.minor_silicon_rev;
            end
            IDX_PART: begin
                rd_data[15:0] = t_reg.cfg.part_number_field;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Configuration capture and table-read guard tightening
    // ------------------------------------------------------------
    // Loaded on every reset cycle so the last one wins. If the memory is
    // not readable the erased image applies, which leaves everything open.
    // Software may only clear table-read guard bits: tightening is allowed,
    // releasing a guard needs a reset, so the loaded policy cannot be undone.
    always_comb begin
        t_next = t_reg;
        if (!aresetn) begin
            t_next.cfg = cfg_valid ? cfg_load : CFG_ERASED;
        end else if (wr_fire && wr_idx == IDX_TBL) begin
            if (wr_strb[0]) begin
                t_next.cfg.block_table_read_guard =
                    t_reg.cfg.block_table_read_guard & wr_data[NBLK-1:0];
            end
            if (wr_strb[1]) begin
                t_next.cfg.boot_table_read_guard =
                    t_reg.cfg.boot_table_read_guard & wr_data[TBL_BOOT_BIT];
            end
        end
        t_next.prog_on = !t_next.cfg.program_read_guard;
        t_next.data_on = !t_next.cfg.data_nvm_read_guard;
    end

    always_ff @(posedge aclk) begin
        t_reg <= t_next;
    end

    assign prog_protect_on = t_reg.prog_on;
    assign data_protect_on = t_reg.data_on;

    // ------------------------------------------------------------
    // Permission checker
    // ------------------------------------------------------------
    nvp_access_check #(
        .NB (NBLK)
    ) u_check (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .wr_lock    (t_reg.cfg.block_self_write_lock),
        .rd_guard   (t_reg.cfg.block_table_read_guard),
        .boot_guard (t_reg.cfg.boot_table_read_guard),
        .req        (mem_req),
        .res        (mem_res)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence rd_take(logic [21:0] idx);
        arvalid && arready && araddr[AXI_AW-1:2] == idx;
    endsequence

    sequence wr_commit(logic [21:0] idx);
        wr_fire && wr_idx == idx;
    endsequence

    // These three watch the load during reset itself, so the default reset
    // gating would mute them; each carries its own never-true disable term
    data_guard_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn && cfg_valid |=> data_protect_on == !$past(cfg_load.data_nvm_read_guard))
        else $error("data protection output does not follow the loaded bit");

    prog_guard_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn && cfg_valid |=> prog_protect_on == !$past(cfg_load.program_read_guard))
        else $error("program protection output does not follow the loaded bit");

    code_default_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn && !cfg_valid |=> !prog_protect_on && !data_protect_on)
        else $error("code protection not off after reset with erased memory");

    code_ro_a: assert property (
        wr_commit(IDX_CODE) |=> $stable(prog_protect_on) && $stable(data_protect_on))
        else $error("software write changed a code protection bit");

    part_word_a: assert property (
        rd_take(IDX_PART) |=> rvalid && rresp == RESP_OKAY
        && rdata == {16'h0, t_reg.cfg.part_number_field})
        else $error("part identifier read back wrong");

    family_bits_a: assert property (
        rd_take(IDX_REV) |=> rvalid && rdata[15:12] == FAMILY_CODE && rdata[31:16] == 16'h0)
        else $error("family pattern read back wrong");

    major_rev_a: assert property (
        rd_take(IDX_REV) |=> rdata[11:6] == t_reg.cfg.major_silicon_rev)
        else $error("major revision read back wrong");

    minor_rev_a: assert property (
        rd_take(IDX_REV) |=> rdata[5:0] == t_reg.cfg.minor_silicon_rev)
        else $error("minor revision read back wrong");

    cfg_hold_a: assert property (
        $past(aresetn) |-> $stable(t_reg.cfg.block_self_write_lock)
        && $stable(t_reg.cfg.part_number_field) && $stable(t_reg.cfg.major_silicon_rev)
        && $stable(t_reg.cfg.minor_silicon_rev) && $stable(t_reg.cfg.program_read_guard)
        && $stable(t_reg.cfg.data_nvm_read_guard))
        else $error("loaded configuration changed outside reset");

    // A guard cleared by software stays cleared: a written one never releases it
    tbl_tighten_a: assert property (
        wr_commit(IDX_TBL) |=> (t_reg.cfg.block_table_read_guard
        & ~$past(t_reg.cfg.block_table_read_guard)) == 4'h0
        && !(t_reg.cfg.boot_table_read_guard && !$past(t_reg.cfg.boot_table_read_guard)))
        else $error("software write released a table-read guard");

endmodule

// ===== tb_nvp_protect_top.sv
// Self-checking testbench for the NVM protection and identification block
module tb_nvp_protect_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvp_pkg::*;

    // Loaded image; the part number value is arbitrary
    localparam nvp_cfg_t CFG = '{4'ha, 1'b0, 1'b1, 1'b0, 4'h5, 16'h1234, 6'h2a, 6'h15};

    logic              aclk, awready, wready, bvalid, arready, rvalid, prog_on, data_on;
    logic              aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0, cfg_valid = 1'b1;
    logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata, rd_val;
    logic [3:0]        wstrb = 4'hf;
    logic [1:0]        bresp, rresp, resp;
    nvp_cfg_t          cfg_load = CFG;
    nvp_req_t          mem_req = '0;
    nvp_res_t          mem_res;
    int                miscompares = 0;
    int                checked = 0;

    nvp_protect_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cfg_load(cfg_load), .cfg_valid(cfg_valid), .mem_req(mem_req), .mem_res(mem_res),
        .prog_protect_on(prog_on), .data_protect_on(data_on));

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for a handshake sampled high at a rising edge
    task automatic hs(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) begin
            miscompares++;
            complete_run();
        end
    endtask

    // Extra edge at the end keeps back-to-back calls from driving twice in one step
    task automatic rdc(input logic [21:0] idx, input logic [31:0] e, input logic [1:0] er);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        hs(arready);
        arvalid <= 1'b0;
        hs(rvalid);
        rd_val = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        chk(rd_val, e);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic wrc(input logic [21:0] idx, input logic [31:0] d, input logic [1:0] er);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                hs(awready);
                awvalid <= 1'b0;
            end
            begin
                hs(wready);
                wvalid <= 1'b0;
            end
        join
        hs(bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    // Answer is sampled at the edge one cycle after the request is taken
    task automatic perm(input logic w, input logic [2:0] t, input logic [2:0] s, input logic a);
        mem_req <= '{1'b1, w, t, s};
        @(posedge aclk);
        mem_req <= '0;
        @(posedge aclk);
        chk({30'h0, mem_res}, {30'h0, 1'b1, a});
    endtask

    task automatic rst(input logic v);
        cfg_valid <= v;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_ident();
        rdc(IDX_PART, 32'h1234, RESP_OKAY);
        rdc(IDX_REV, {16'h0, FAMILY_CODE, 6'h2a, 6'h15}, RESP_OKAY);
        wrc(IDX_PART, 32'h0, RESP_OKAY);
        rdc(IDX_PART, 32'h1234, RESP_OKAY);
        rdc(22'h000001, 32'h0, RESP_SLVERR);
        wrc(22'h000001, 32'h0, RESP_SLVERR);
        $display("test ident done");
    endtask

    task automatic t_code();
        rdc(IDX_CODE, 32'h1, RESP_OKAY);
        chk({31'h0, data_on}, 32'h1);
        chk({31'h0, prog_on}, 32'h0);
        wrc(IDX_CODE, 32'h0, RESP_OKAY);
        rdc(IDX_CODE, 32'h1, RESP_OKAY);
        $display("test code done");
    endtask

    task automatic t_perm();
        rdc(IDX_LOCK, 32'ha, RESP_OKAY);
        perm(1'b1, 3'h0, 3'h1, 1'b0);
        perm(1'b1, 3'h1, 3'h0, 1'b1);
        perm(1'b0, 3'h1, 3'h0, 1'b0);
        perm(1'b0, 3'h1, 3'h1, 1'b1);
        perm(1'b0, 3'h0, 3'h2, 1'b1);
        perm(1'b0, 3'h4, 3'h0, 1'b0);
        perm(1'b0, 3'h4, 3'h4, 1'b1);
        $display("test perm done");
    endtask

    // Guards only tighten at run time, and a reset with the memory unreadable brings in the erased image
    task automatic t_hold();
        rdc(IDX_TBL, 32'h5, RESP_OKAY);
        wrc(IDX_TBL, 32'h0, RESP_OKAY);
        rdc(IDX_TBL, 32'h0, RESP_OKAY);
        wrc(IDX_TBL, 32'h20f, RESP_OKAY);
        rdc(IDX_TBL, 32'h0, RESP_OKAY);
        perm(1'b0, 3'h0, 3'h2, 1'b0);
        rst(1'b0);
        cfg_valid <= 1'b1;
        cfg_load <= '0;
        rdc(IDX_CODE, 32'h3, RESP_OKAY);
        chk({30'h0, data_on, prog_on}, 32'h0);
        rdc(IDX_TBL, 32'h20f, RESP_OKAY);
        rdc(IDX_PART, 32'hffff, RESP_OKAY);
        $display("test hold done");
    endtask

    initial begin
        rst(1'b1);
        t_ident();
        t_code();
        t_perm();
        t_hold();
        complete_run();
    end
endmodule
